// [common/cwp_params.svh]
// Purpose: Offsets, field positions, resets, counts
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef CWP_PARAMS_SVH
`define CWP_PARAMS_SVH
// ****************************************
// Register offsets
// ****************************************
`define CWP_OFS_WDT_CFG 16'h8009
`define CWP_OFS_PROT_CFG 16'h800a
`define CWP_OFS_WDT_CTRL 16'h0010
`define CWP_OFS_STATUS 16'h0011
// ****************************************
// Field positions
// ****************************************
`define CWP_MODE_HI 6
`define CWP_MODE_LO 5
`define CWP_PER_HI 4
`define CWP_PER_LO 0
`define CWP_LVP_BIT 13
`define CWP_STORE_WP_BIT 11
`define CWP_EEPROM_WP_BIT 10
`define CWP_CFG_WP_BIT 9
`define CWP_BOOT_WP_BIT 8
`define CWP_APP_WP_BIT 7
`define CWP_STORE_EN_N_BIT 4
`define CWP_BOOT_EN_N_BIT 3
`define CWP_BSIZE_HI 2
`define CWP_BSIZE_LO 0
`define CWP_CTRL_EN_BIT 0
`define CWP_CTRL_PER_HI 5
`define CWP_CTRL_PER_LO 1
// ****************************************
// Masks, resets and counts
// ****************************************
`define CWP_WDT_MASK 16'h3f7f
`define CWP_PROT_MASK 16'h2f9f
`define CWP_SOFT_PER_RESET 5'h0b
`define CWP_PER_SOFT_CODE 5'h1f
`define CWP_PER_MAX_CODE 5'h12
`define CWP_PER_BASE_EXP 5'h05
`define CWP_BOOT_MIN_WORDS 14'h0200
`define CWP_BOOT_MAX_SHIFT 3'h4
`define CWP_BSIZE_TOP 3'h7
`endif

// [common/cwp_pkg.sv]
// Purpose: Types of the config word decoder
// Assumes: Nothing
// Notes: Constants live in cwp_params.svh
package cwp_pkg;
    // Watchdog operating modes
    typedef enum logic [1:0] {
        CWP_WDT_OFF = 2'h0,
        CWP_WDT_SOFT = 2'h1,
        CWP_WDT_AWAKE = 2'h2,
        CWP_WDT_ALWAYS = 2'h3
    } cwp_wdt_mode_t;
    // Load phase after reset
    typedef enum logic [0:0] {
        CWP_PH_LOAD = 1'h0,
        CWP_PH_RUN = 1'h1
    } cwp_phase_t;
endpackage : cwp_pkg

// [hdl/cwp_config_decode.sv]
// Purpose: Decode watchdog and write protect config words
// Assumes: NVM words stable around reset release
// Notes: Protect decode outputs change only at reset; watchdog enable and period also follow sleep and control writes
`include "cwp_params.svh"
module cwp_config_decode
    import cwp_pkg::*;
#(
    parameter int PROG_MEM_WORDS = 16384
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [15:0] nvm_wdt_word,
    input wire logic [15:0] nvm_prot_word,
    input wire logic nvm_reset_pin_enable,
    input wire logic lvp_session,
    input wire logic core_sleep,
    output logic decode_valid,
    output logic wdt_enable,
    output logic [4:0] wdt_div_exp,
    output logic reset_pin_is_reset,
    output logic lv_prog_entry_allowed,
    output logic hv_prog_only,
    output logic store_wr_allow,
    output logic eeprom_wr_allow,
    output logic config_wr_allow,
    output logic boot_wr_allow,
    output logic app_wr_allow,
    output logic storage_area_enable,
    output logic [13:0] boot_block_words,
    output logic [13:0] boot_block_last_addr,
    output logic [15:0] wdt_word_out,
    output logic [15:0] prot_word_out
);
    // Half of program memory, boot block ceiling
    localparam logic [13:0] HALF_WORDS = 14'(PROG_MEM_WORDS / 2);

    // ****************************************
    // Helper functions
    // ****************************************
    // Divider exponent for a period code
    function automatic logic [4:0] per_exp(input logic [4:0] code);
        logic [4:0] e;
        e = `CWP_PER_BASE_EXP;
        if (code <= `CWP_PER_MAX_CODE) begin
            e = code + `CWP_PER_BASE_EXP;
        end
        return e;
    endfunction : per_exp

    // Boot block words from enable and size code
    function automatic logic [13:0] boot_words(input logic en_n,
                                               input logic [2:0] code);
        logic [2:0] sh;
        logic [13:0] w;
        sh = `CWP_BSIZE_TOP - code;
        w = 14'h0000;
        if (sh > `CWP_BOOT_MAX_SHIFT) begin
            sh = `CWP_BOOT_MAX_SHIFT;
        end
        if (!en_n) begin
            w = `CWP_BOOT_MIN_WORDS << sh;
            if (w > HALF_WORDS) begin
                w = HALF_WORDS;
            end
        end
        return w;
    endfunction : boot_words

    // ****************************************
    // Address decode
    // ****************************************
    // Strobes qualified by clock enable
    logic wr_wdt_cfg;
    logic wr_prot_cfg;
    logic wr_ctrl;
    assign wr_wdt_cfg = ce && reg_wr && (reg_addr == `CWP_OFS_WDT_CFG);
    assign wr_prot_cfg = ce && reg_wr && (reg_addr == `CWP_OFS_PROT_CFG);
    assign wr_ctrl = ce && reg_wr && (reg_addr == `CWP_OFS_WDT_CTRL);

    // ****************************************
    // Load phase and latched decode
    // ****************************************
    cwp_phase_t phase_ff;       // Load or run
    cwp_phase_t nxt_phase;
    logic [15:0] dec_wdt_ff;    // Latched watchdog word
    logic [15:0] nxt_dec_wdt;
    logic [15:0] dec_prot_ff;   // Latched protect word
    logic [15:0] nxt_dec_prot;
    logic dec_pin_en_ff;        // Latched reset pin enable
    logic nxt_dec_pin_en;

    // Capture NVM words once after reset release
    always_comb begin
        nxt_phase = phase_ff;
        nxt_dec_wdt = dec_wdt_ff;
        nxt_dec_prot = dec_prot_ff;
        nxt_dec_pin_en = dec_pin_en_ff;
        case (phase_ff)
            CWP_PH_LOAD: begin
                // Take words, then hold till reset
                nxt_dec_wdt = nvm_wdt_word & `CWP_WDT_MASK;
                nxt_dec_prot = nvm_prot_word & `CWP_PROT_MASK;
                nxt_dec_pin_en = nvm_reset_pin_enable;
                nxt_phase = CWP_PH_RUN;
            end
            CWP_PH_RUN: begin
                nxt_phase = CWP_PH_RUN;
            end
            default: begin
                nxt_phase = CWP_PH_LOAD;
            end
        endcase
    end

    // Register load phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= CWP_PH_LOAD;
            dec_wdt_ff <= 16'h0000;
            dec_prot_ff <= 16'h0000;
            dec_pin_en_ff <= 1'b0;
        end else if (ce) begin
            phase_ff <= nxt_phase;
            dec_wdt_ff <= nxt_dec_wdt;
            dec_prot_ff <= nxt_dec_prot;
            dec_pin_en_ff <= nxt_dec_pin_en;
        end
    end

    // Decoded fields
    cwp_wdt_mode_t dec_mode;
    logic [4:0] dec_per;
    assign dec_mode = cwp_wdt_mode_t'(dec_wdt_ff[`CWP_MODE_HI:`CWP_MODE_LO]);
    assign dec_per = dec_wdt_ff[`CWP_PER_HI:`CWP_PER_LO];

    // ****************************************
    // Programmer words and watchdog control
    // ****************************************
    logic [15:0] wdt_cfg_ff;    // Stored watchdog word
    logic [15:0] nxt_wdt_cfg;
    logic [15:0] prot_cfg_ff;   // Stored protect word
    logic [15:0] nxt_prot_cfg;
    logic soft_en_ff;           // Software watchdog enable
    logic nxt_soft_en;
    logic [4:0] soft_per_ff;    // Software period code
    logic [4:0] nxt_soft_per;

    // Load from NVM, then accept guarded writes
    always_comb begin
        nxt_wdt_cfg = wdt_cfg_ff;
        nxt_prot_cfg = prot_cfg_ff;
        nxt_soft_en = soft_en_ff;
        nxt_soft_per = soft_per_ff;
        if (phase_ff == CWP_PH_LOAD) begin
            // Mirror NVM contents
            nxt_wdt_cfg = nvm_wdt_word & `CWP_WDT_MASK;
            nxt_prot_cfg = nvm_prot_word & `CWP_PROT_MASK;
        end else begin
            if (wr_wdt_cfg) begin
                nxt_wdt_cfg = reg_wdata & `CWP_WDT_MASK;
            end
            if (wr_prot_cfg) begin
                nxt_prot_cfg = reg_wdata & `CWP_PROT_MASK;
                // Clearing refused in low voltage session
                if (lvp_session && prot_cfg_ff[`CWP_LVP_BIT]) begin
                    nxt_prot_cfg[`CWP_LVP_BIT] = 1'b1;
                end
                // Size frozen once boot block enabled
                if (!prot_cfg_ff[`CWP_BOOT_EN_N_BIT]) begin
                    nxt_prot_cfg[`CWP_BSIZE_HI:`CWP_BSIZE_LO] =
                        prot_cfg_ff[`CWP_BSIZE_HI:`CWP_BSIZE_LO];
                end
            end
            if (wr_ctrl) begin
                nxt_soft_en = reg_wdata[`CWP_CTRL_EN_BIT];
                // Period writable only under software control
                if (dec_per == `CWP_PER_SOFT_CODE) begin
                    nxt_soft_per = reg_wdata[`CWP_CTRL_PER_HI:`CWP_CTRL_PER_LO];
                end
            end
        end
    end

    // Register programmer words
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cfg_ff <= 16'h0000;
            prot_cfg_ff <= 16'h0000;
            soft_en_ff <= 1'b0;
            soft_per_ff <= `CWP_SOFT_PER_RESET;
        end else if (ce) begin
            wdt_cfg_ff <= nxt_wdt_cfg;
            prot_cfg_ff <= nxt_prot_cfg;
            soft_en_ff <= nxt_soft_en;
            soft_per_ff <= nxt_soft_per;
        end
    end

    // ****************************************
    // Decoded outputs
    // ****************************************
    logic valid_ff;             // Decode taken
    logic wdt_en_ff;            // Watchdog running
    logic [4:0] exp_ff;         // Divider exponent
    logic [8:0] flags_ff;       // Pin and protect flags
    logic [13:0] bwords_ff;     // Boot block words
    logic nxt_valid;
    logic nxt_wdt_en;
    logic [4:0] nxt_exp;
    logic [8:0] nxt_flags;
    logic [13:0] nxt_bwords;

    // Compute watchdog and protection outputs
    always_comb begin
        nxt_valid = (phase_ff == CWP_PH_RUN);
        nxt_wdt_en = 1'b0;
        nxt_exp = per_exp(dec_per);
        nxt_flags = 9'h000;
        nxt_bwords = 14'h0000;
        if (phase_ff == CWP_PH_RUN) begin
            case (dec_mode)
                CWP_WDT_ALWAYS: nxt_wdt_en = 1'b1;
                CWP_WDT_AWAKE: nxt_wdt_en = !core_sleep;
                CWP_WDT_SOFT: nxt_wdt_en = soft_en_ff;
                CWP_WDT_OFF: nxt_wdt_en = 1'b0;
                default: nxt_wdt_en = 1'b0;
            endcase
            if (dec_per == `CWP_PER_SOFT_CODE) begin
                nxt_exp = per_exp(soft_per_ff);
            end
            // Reset pin, entry modes
            nxt_flags[0] = dec_prot_ff[`CWP_LVP_BIT] || dec_pin_en_ff;
            nxt_flags[1] = dec_prot_ff[`CWP_LVP_BIT];
            nxt_flags[2] = !dec_prot_ff[`CWP_LVP_BIT];
            // Region write permissions, storage area enable
            nxt_flags[3] = dec_prot_ff[`CWP_STORE_WP_BIT];
            nxt_flags[4] = dec_prot_ff[`CWP_EEPROM_WP_BIT];
            nxt_flags[5] = dec_prot_ff[`CWP_CFG_WP_BIT];
            nxt_flags[6] = dec_prot_ff[`CWP_BOOT_WP_BIT];
            nxt_flags[7] = dec_prot_ff[`CWP_APP_WP_BIT];
            nxt_flags[8] = !dec_prot_ff[`CWP_STORE_EN_N_BIT];
            nxt_bwords = boot_words(dec_prot_ff[`CWP_BOOT_EN_N_BIT],
                dec_prot_ff[`CWP_BSIZE_HI:`CWP_BSIZE_LO]);
        end
    end

    // Register decoded outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            wdt_en_ff <= 1'b0;
            exp_ff <= `CWP_PER_BASE_EXP;
            flags_ff <= 9'h000;
            bwords_ff <= 14'h0000;
        end else if (ce) begin
            valid_ff <= nxt_valid;
            wdt_en_ff <= nxt_wdt_en;
            exp_ff <= nxt_exp;
            flags_ff <= nxt_flags;
            bwords_ff <= nxt_bwords;
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    logic [15:0] rdata_ff;      // Read data, one cycle later
    logic [15:0] nxt_rdata;

    // Mux read data, unmapped reads zero
    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `CWP_OFS_WDT_CFG: nxt_rdata = wdt_cfg_ff;
                `CWP_OFS_PROT_CFG: nxt_rdata = prot_cfg_ff;
                `CWP_OFS_WDT_CTRL: nxt_rdata = {10'h000, soft_per_ff, soft_en_ff};
                `CWP_OFS_STATUS: nxt_rdata = {9'h000, valid_ff, exp_ff, wdt_en_ff};
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Register read data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else if (ce) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Output wiring
    assign reg_rdata = rdata_ff;
    assign decode_valid = valid_ff;
    assign wdt_enable = wdt_en_ff;
    assign wdt_div_exp = exp_ff;
    assign reset_pin_is_reset = flags_ff[0];
    assign lv_prog_entry_allowed = flags_ff[1];
    assign hv_prog_only = flags_ff[2];
    assign store_wr_allow = flags_ff[3];
    assign eeprom_wr_allow = flags_ff[4];
    assign config_wr_allow = flags_ff[5];
    assign boot_wr_allow = flags_ff[6];
    assign app_wr_allow = flags_ff[7];
    assign storage_area_enable = flags_ff[8];
    assign boot_block_words = bwords_ff;
    assign boot_block_last_addr = bwords_ff - 14'h0001;
    assign wdt_word_out = wdt_cfg_ff;
    assign prot_word_out = prot_cfg_ff;

    // ****************************************
    // Assertions
    // ****************************************
    // Run cycle with clock enable
    logic run_ce;
    assign run_ce = ce && (phase_ff == CWP_PH_RUN);

    // Guarded protect word write
    sequence s_lvp_guard;
        wr_prot_cfg && run_ce && lvp_session && prot_cfg_ff[`CWP_LVP_BIT];
    endsequence
    sequence s_size_guard;
        wr_prot_cfg && run_ce && !prot_cfg_ff[`CWP_BOOT_EN_N_BIT];
    endsequence

    a_mode_always: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_ce && dec_mode == CWP_WDT_ALWAYS |=> wdt_enable)
        else $error("watchdog not running in always mode");
    a_mode_awake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_ce && dec_mode == CWP_WDT_AWAKE |=> wdt_enable == !$past(core_sleep))
        else $error("watchdog not suspended in sleep");
    a_mode_soft: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_ce && dec_mode == CWP_WDT_SOFT |=> wdt_enable == $past(soft_en_ff))
        else $error("watchdog ignores software enable");
    a_mode_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_ce && dec_mode == CWP_WDT_OFF |=> !wdt_enable)
        else $error("watchdog running while off");
    a_period_fixed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_ce && dec_per <= `CWP_PER_MAX_CODE |=> wdt_div_exp == $past(dec_per) + 5'h05)
        else $error("wrong divider exponent");
    a_soft_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_ctrl && dec_per != `CWP_PER_SOFT_CODE |=> $stable(soft_per_ff))
        else $error("software period changed while fixed");
    a_lvp_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
        decode_valid && dec_prot_ff[`CWP_LVP_BIT] |-> reset_pin_is_reset && lv_prog_entry_allowed)
        else $error("reset pin not reset under low voltage");
    a_hv_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        decode_valid |-> hv_prog_only == !dec_prot_ff[`CWP_LVP_BIT])
        else $error("entry mode flags disagree");
    a_lvp_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_lvp_guard |=> prot_cfg_ff[`CWP_LVP_BIT])
        else $error("low voltage bit cleared in session");
    a_store_wp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        run_ce |=> store_wr_allow == $past(dec_prot_ff[`CWP_STORE_WP_BIT]))
        else $error("storage area permission wrong");
    a_boot_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        decode_valid && dec_prot_ff[`CWP_BOOT_EN_N_BIT] |-> boot_block_words == 14'h0000)
        else $error("disabled boot block not zero");
    a_size_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_size_guard |=> $stable(prot_cfg_ff[`CWP_BSIZE_HI:`CWP_BSIZE_LO]))
        else $error("boot size written while locked");
    a_boot_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
        boot_block_words <= HALF_WORDS)
        else $error("boot block above half memory");
    a_decode_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        decode_valid && ce |=> $stable(boot_block_words) && $stable(config_wr_allow))
        else $error("decoded settings changed after load");

endmodule : cwp_config_decode

// [bench/cwp_prog_model.sv]
// Purpose: Programmer model holding the NVM config words
// Assumes: Words change only while the decoder sits in reset
// Notes: Erased cells read as ones, so the words start all ones
module cwp_prog_model (
    input wire logic ref_clk,
    output logic [15:0] nvm_wdt_word,
    output logic [15:0] nvm_prot_word,
    output logic nvm_reset_pin_enable,
    output logic lvp_session
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Stored words and session state
    // ****************************************
    initial begin
        nvm_wdt_word = 16'hffff; // Erased watchdog word
        nvm_prot_word = 16'hffff; // Erased protect word
        nvm_reset_pin_enable = 1'b1; // Erased pin enable bit
        lvp_session = 1'b0; // High voltage session by default
    end
    // Programs new words just after a clock edge
    task automatic program_words(input logic [15:0] w, input logic [15:0] p,
                                 input logic rpe, input logic low_voltage_prog_enable);
        @(posedge ref_clk);
        nvm_wdt_word <= w;
        nvm_prot_word <= p;
        nvm_reset_pin_enable <= rpe;
        lvp_session <= low_voltage_prog_enable;
    endtask : program_words
    // Switches the entry kind of the running session
    task automatic set_session(input logic low_voltage_prog_enable);
        @(posedge ref_clk);
        lvp_session <= low_voltage_prog_enable;
    endtask : set_session
endmodule : cwp_prog_model

// [bench/cwp_config_decode_tb.sv]
// Purpose: Self-checking bench of the config word decoder
// Assumes: Program memory of 8192 words, so the half-size cap shows
// Notes: Every decode case needs its own reset, decode is latched
`include "cwp_params.svh"
module cwp_config_decode_tb
    import cwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MEM_WORDS = 8192;
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic core_sleep = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, rd;
    logic [15:0] nvm_wdt_word, nvm_prot_word, wdt_word_out, prot_word_out;
    logic nvm_reset_pin_enable, lvp_session, decode_valid, wdt_enable;
    logic reset_pin_is_reset, lv_prog_entry_allowed, hv_prog_only, storage_area_enable;
    logic store_wr_allow, eeprom_wr_allow, config_wr_allow, boot_wr_allow, app_wr_allow;
    logic [4:0] wdt_div_exp, ex;
    logic [13:0] boot_block_words, boot_block_last_addr;
    logic [4:0] pers [4] = '{5'h00, 5'h12, 5'h13, 5'h1e}; // Period codes per mode
    logic [15:0] prots [6] = '{16'h2f9f, 16'h0007, 16'h2a86, 16'h0515, 16'h0000, 16'h0004};
    int err_count = 0, checked = 0;
    // ****************************************
    // Clock, partner and design
    // ****************************************
    always #5 ref_clk = ~ref_clk;
    cwp_prog_model i_prog (.ref_clk, .nvm_wdt_word, .nvm_prot_word, .nvm_reset_pin_enable,
                           .lvp_session);
    cwp_config_decode #(.PROG_MEM_WORDS(MEM_WORDS)) i_dut (.ref_clk, .rst_n, .ce, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nvm_wdt_word, .nvm_prot_word,
        .nvm_reset_pin_enable, .lvp_session, .core_sleep, .decode_valid, .wdt_enable,
        .wdt_div_exp, .reset_pin_is_reset, .lv_prog_entry_allowed, .hv_prog_only,
        .store_wr_allow, .eeprom_wr_allow, .config_wr_allow, .boot_wr_allow, .app_wr_allow,
        .storage_area_enable, .boot_block_words, .boot_block_last_addr, .wdt_word_out,
        .prot_word_out);
    // ****************************************
    // Report, compare and bus tasks
    // ****************************************
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // Compares one value, narrower ones zero-extended
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // One-cycle write strobe, settles past the sampling edge
    task automatic reg_write(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write
    // One-cycle read strobe, data taken in the following cycle
    task automatic reg_read(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    // Loads new words, resets, checks reset levels, waits for decode
    task automatic boot(input logic [15:0] w, input logic [15:0] p, input logic rpe,
                        input logic low_voltage_prog_enable);
        int n;
        i_prog.program_words(w, p, rpe, low_voltage_prog_enable);
        rst_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        chk(wdt_div_exp, 16'h0005, "reset period");
        chk(decode_valid, 16'h0000, "reset valid");
        rst_n <= 1'b1;
        for (n = 0; n < 8 && decode_valid !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (decode_valid !== 1'b1) begin
            chk(decode_valid, 16'h0001, "decode timeout");
            summarize();
        end
    endtask : boot
    // Checks every protect decode output against the loaded word
    task automatic chk_prot(input logic [15:0] p, input logic rpe);
        logic [13:0] sz;
        sz = (p[2:0] >= 3'h4) ? (14'h0200 << (3'h7 - p[2:0])) : 14'h2000;
        sz = (sz > 14'(MEM_WORDS / 2)) ? 14'(MEM_WORDS / 2) : sz;
        sz = p[3] ? 14'h0000 : sz;
        chk(lv_prog_entry_allowed, p[13], "lv entry");
        chk(hv_prog_only, !p[13], "hv only");
        chk(reset_pin_is_reset, p[13] | rpe, "reset pin");
        chk(store_wr_allow, p[11], "store wr");
        chk(eeprom_wr_allow, p[10], "eeprom wr");
        chk(config_wr_allow, p[9], "config wr");
        chk(boot_wr_allow, p[8], "boot wr");
        chk(app_wr_allow, p[7], "app wr");
        chk(storage_area_enable, !p[4], "store en");
        chk(boot_block_words, sz, "boot words");
        if (sz != 14'h0000) begin
            chk(boot_block_last_addr, sz - 14'h0001, "boot last");
        end
        reg_read(`CWP_OFS_PROT_CFG, rd);
        chk(rd, p & `CWP_PROT_MASK, "prot read");
    endtask : chk_prot
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        // Every watchdog mode, with plain and out-of-table periods
        for (int i = 0; i < 4; i++) begin
            ex = (pers[i] <= 5'h12) ? pers[i] + 5'h05 : 5'h05;
            boot(16'hff80 | {9'h000, 2'(i), pers[i]}, 16'h2f9f, 1'b0, 1'b0);
            chk(wdt_word_out, (16'hff80 | {9'h000, 2'(i), pers[i]}) & `CWP_WDT_MASK, "wdt word");
            chk(wdt_enable, i >= 2, "mode no soft");
            chk(wdt_div_exp, ex, "period");
            reg_write(`CWP_OFS_WDT_CTRL, 16'h0005);
            repeat (3) @(posedge ref_clk);
            #1;
            chk(wdt_enable, i != 0, "mode soft on");
            chk(wdt_div_exp, ex, "period locked");
            @(posedge ref_clk) core_sleep <= 1'b1;
            repeat (3) @(posedge ref_clk);
            #1;
            chk(wdt_enable, i == 1 || i == 3, "mode asleep");
            @(posedge ref_clk) core_sleep <= 1'b0;
            reg_write(`CWP_OFS_STATUS, 16'hffff);
            repeat (3) @(posedge ref_clk);
            reg_read(`CWP_OFS_STATUS, rd);
            chk(rd, {9'h000, 1'b1, ex, i != 0}, "status");
        end
        // Software period: reset value, then a new one
        boot(16'h005f, 16'h2f9f, 1'b0, 1'b0);
        chk(wdt_div_exp, 5'h05 + `CWP_SOFT_PER_RESET, "soft reset");
        reg_write(`CWP_OFS_WDT_CTRL, 16'h0006);
        repeat (2) @(posedge ref_clk);
        #1;
        chk(wdt_div_exp, 16'h0008, "soft period");
        // Protect decode table, pin enable alternating
        for (int i = 0; i < 6; i++) begin
            boot(16'h0000, prots[i], i[0], 1'b0);
            chk_prot(prots[i], i[0]);
        end
        // Size field locked while boot block enabled, decode held
        boot(16'h0000, 16'h0006, 1'b0, 1'b0);
        reg_write(`CWP_OFS_PROT_CFG, 16'h2f99);
        chk(prot_word_out, 16'h2f9e, "size locked");
        chk(boot_block_words, 14'h0400, "decode held");
        chk(store_wr_allow, 16'h0000, "wp held");
        reg_write(`CWP_OFS_PROT_CFG, 16'h2f9b);
        chk(prot_word_out, 16'h2f9b, "size free");
        // Clock enable low freezes the stored word against a write
        @(posedge ref_clk) ce <= 1'b0;
        reg_write(`CWP_OFS_PROT_CFG, 16'h0000);
        @(posedge ref_clk) ce <= 1'b1;
        chk(prot_word_out, 16'h2f9b, "ce freeze");
        // Low voltage bit cannot be cleared from a low voltage session
        boot(16'h0000, 16'h2000, 1'b0, 1'b1);
        reg_write(`CWP_OFS_PROT_CFG, 16'h0000);
        chk(prot_word_out, 16'h2000, "lv kept");
        i_prog.set_session(1'b0);
        reg_write(`CWP_OFS_PROT_CFG, 16'h0000);
        chk(prot_word_out, 16'h0000, "hv clears");
        chk(lv_prog_entry_allowed, 16'h0001, "lv held");
        // Unmapped read answers zero
        reg_read(16'h1234, rd);
        chk(rd, 16'h0000, "unmapped");
        summarize();
    end
endmodule : cwp_config_decode_tb
